// file: rtl/aaw_defines.svh
`ifndef AAW_DEFINES_SVH
`define AAW_DEFINES_SVH
// register indices; byte address is four times the index
`define AAW_IDX_POLICY      8'h0D
`define AAW_IDX_CODE        8'h0E
`define AAW_IDX_RSVD        8'h0F
`define AAW_IDX_KICK        8'h10
`define AAW_IDX_IDENT       8'h11
`define AAW_IDX_FAULTS      8'h12
// reset values
`define AAW_POLICY_RST      16'h0000
`define AAW_CODE_RST        16'h0000
// field positions
`define AAW_CRCWD_HI        7
`define AAW_CRCWD_LO        6
`define AAW_OPEN_HI         5
`define AAW_OPEN_LO         4
`define AAW_SHORT_HI        3
`define AAW_SHORT_LO        2
`define AAW_HEAT_HI         1
`define AAW_HEAT_LO         0
`define AAW_VAL_HI          15
`define AAW_VAL_LO          10
`define AAW_CLAMP_BIT       9
`define AAW_KICK_BIT        0
`define AAW_WDF_BIT         11
`define AAW_CRCF_BIT        5
// policy codes
`define AAW_ACT_NONE        2'h0
`define AAW_ACT_CODE        2'h1
`define AAW_ACT_OFF         2'h2
`endif

// file: rtl/aaw_pkg.sv
package aaw_pkg;
  // bus slave phases
  typedef enum logic [1:0] {
    AAW_IDLE,
    AAW_ANSWER
  } aaw_phase_e;
  // per-channel bit vector
  typedef logic [3:0] aaw_chan_t;
endpackage

// file: rtl/aaw_action.sv
`include "aaw_defines.svh"
// combinational policy decode of one fault class
module aaw_action (
  input  wire logic [1:0] code_in,       // policy field
  input  wire logic [3:0] fault_in,      // per-channel fault levels
  input  wire logic       all_chan_in,   // code applies to every channel
  output logic      [3:0] subst_out,     // channels to substitute
  output logic            off_out        // shutdown request
);
  // 11 behaves like 00
  always_comb begin
    subst_out = 4'h0;
    off_out   = 1'b0;
    if (code_in == `AAW_ACT_CODE) begin
      subst_out = all_chan_in ? {4{|fault_in}} : fault_in;
    end else if (code_in == `AAW_ACT_OFF) begin
      off_out = |fault_in;
    end
  end
endmodule

// file: rtl/aaw_kick.sv
// self-clearing one-cycle watchdog restart pulse
module aaw_kick (
  input  wire logic ref_clk_in,  // system clock
  input  wire logic rst_in,      // sync reset
  input  wire logic set_in,      // write of one to the kick bit
  output logic      pulse_out    // restart pulse
);
  // register: bit clears itself one cycle after being set
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= set_in;
    end
  end
endmodule

// file: rtl/aaw_regs.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "aaw_defines.svh"
// Summary of operation
// - policy register 0x0D rw, resets zero
// - bits 7:6 crc/watchdog response
// - bits 5:4 open-current response, per channel
// - bits 3:2 short-voltage response, per channel
// - bits 1:0 overheat response
// - shutdown latches until reset
// - alarm code register 0x0E rw, resets zero
// - bits 15:10 user alarm value
// - bit 9 clamp select 32/26 V
// - 0x0F reserved, reads zero
// - 0x10 write-only watchdog service register
// - kick bit restarts timer, self clears
// - 0x11 read-only identity code bits 2:0
// - watchdog fault sets flag bit 11
// - crc error sets flag bit 5
module aaw_regs #(
  parameter logic [2:0] ID_CODE = 3'h5  // identity value, arbitrary
) (
  input  wire logic        ref_clk_in,         // system clock
  input  wire logic        rst_in,             // sync reset, high
  input  wire logic [7:0]  avs_address,        // word address
  input  wire logic        avs_read,           // read request
  input  wire logic        avs_write,          // write request
  input  wire logic [31:0] avs_writedata,      // write data
  input  wire logic [3:0]  avs_byteenable,     // byte lanes
  output logic      [31:0] avs_readdata,       // read data
  output logic             avs_waitrequest,    // stall
  output logic      [1:0]  avs_response,       // 00 ok, 10 slave error
  input  wire logic        crc_err_in,         // crc error event pulse
  input  wire logic        wd_fault_in,        // watchdog fault event pulse
  input  wire logic [3:0]  open_current_in,    // open-circuit levels
  input  wire logic [3:0]  short_voltage_in,   // short-circuit levels
  input  wire logic        overheat_in,        // over-temperature level
  output logic      [3:0]  chan_disable_out,   // channel disables
  output logic             conv_disable_out,   // converter disable
  output logic      [3:0]  subst_out,          // substitute alarm value
  output logic      [5:0]  user_alarm_value_out, // alarm value
  output logic             high_side_clamp_select_out, // 1 = 26 V
  output logic             watchdog_kick_out   // restart pulse
);
  // all state
  typedef struct packed {
    aaw_pkg::aaw_phase_e phase;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [7:0]  policy;
    logic [6:0]  code;   // value 15:10 and clamp 9
    logic        wdf;    // watchdog fault flag
    logic        crcf;   // crc fault flag
    logic        shut;   // latched shutdown
    logic [3:0]  subst;
  } aaw_state_s;

  aaw_state_s st_r;   // registered state
  aaw_state_s st_nxt; // next state
  logic [3:0] crc_sub;  // decoded substitutions
  logic [3:0] open_sub;
  logic [3:0] short_sub;
  logic [3:0] heat_sub;
  logic crc_off;        // decoded shutdowns
  logic open_off;
  logic short_off;
  logic heat_off;
  logic kick_set;       // kick write seen
  logic wr_acc;         // write accepted this cycle
  logic fault_crcwd;    // any crc/watchdog fault level

  // crc/watchdog faults act while their flags stand
  assign fault_crcwd = st_r.wdf | st_r.crcf;

  aaw_action u_crcwd (.code_in(st_r.policy[`AAW_CRCWD_HI:`AAW_CRCWD_LO]),
    .fault_in({4{fault_crcwd}}), .all_chan_in(1'b1), .subst_out(crc_sub), .off_out(crc_off));
  aaw_action u_open (.code_in(st_r.policy[`AAW_OPEN_HI:`AAW_OPEN_LO]),
    .fault_in(open_current_in), .all_chan_in(1'b0), .subst_out(open_sub), .off_out(open_off));
  aaw_action u_short (.code_in(st_r.policy[`AAW_SHORT_HI:`AAW_SHORT_LO]),
    .fault_in(short_voltage_in), .all_chan_in(1'b0), .subst_out(short_sub), .off_out(short_off));
  aaw_action u_heat (.code_in(st_r.policy[`AAW_HEAT_HI:`AAW_HEAT_LO]),
    .fault_in({4{overheat_in}}), .all_chan_in(1'b1), .subst_out(heat_sub), .off_out(heat_off));

  aaw_kick u_kick (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .set_in     (kick_set),
    .pulse_out  (watchdog_kick_out)
  );

  // a request is answered one cycle after it is seen
  assign wr_acc   = avs_write && st_r.phase == aaw_pkg::AAW_ANSWER;
  assign kick_set = wr_acc && avs_address == `AAW_IDX_KICK && avs_byteenable[0]
                    && avs_writedata[`AAW_KICK_BIT];

  // read mux
  function automatic logic [31:0] rd_word(input aaw_state_s s, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    case (a)
      `AAW_IDX_POLICY: rd_word = {24'h000000, s.policy};
      `AAW_IDX_CODE:   rd_word = {16'h0000, s.code, 9'h000};
      `AAW_IDX_IDENT:  rd_word = {29'h00000000, ID_CODE};
      `AAW_IDX_FAULTS: rd_word = {20'h00000, s.wdf, 5'h00, s.crcf, 5'h00};
      default:         rd_word = 32'h0000_0000; // reserved and kick read zero
    endcase
  endfunction

  // address in map
  function automatic logic mapped(input logic [7:0] a);
    mapped = a >= `AAW_IDX_POLICY && a <= `AAW_IDX_FAULTS;
  endfunction

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.resp = 2'h0;
    case (st_r.phase)
      aaw_pkg::AAW_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.phase = aaw_pkg::AAW_ANSWER;
          st_nxt.rdata = rd_word(st_r, avs_address);
          st_nxt.resp  = mapped(avs_address) ? 2'h0 : 2'h2;
        end
      end
      aaw_pkg::AAW_ANSWER: begin
        st_nxt.phase = aaw_pkg::AAW_IDLE;
        st_nxt.rdata = 32'h0000_0000;
      end
      default: st_nxt.phase = aaw_pkg::AAW_IDLE;
    endcase
    // register writes; upper byte of policy is reserved
    if (wr_acc && avs_address == `AAW_IDX_POLICY && avs_byteenable[0]) begin
      st_nxt.policy = avs_writedata[7:0];
    end
    if (wr_acc && avs_address == `AAW_IDX_CODE && avs_byteenable[1]) begin
      st_nxt.code = avs_writedata[`AAW_VAL_HI:`AAW_CLAMP_BIT];
    end
    // flags: writing one clears, a new event wins
    if (wr_acc && avs_address == `AAW_IDX_FAULTS) begin
      if (avs_byteenable[1] && avs_writedata[`AAW_WDF_BIT]) st_nxt.wdf = 1'b0;
      if (avs_byteenable[0] && avs_writedata[`AAW_CRCF_BIT]) st_nxt.crcf = 1'b0;
    end
    if (wd_fault_in) st_nxt.wdf = 1'b1;
    if (crc_err_in) st_nxt.crcf = 1'b1;
    // shutdown sticks until reset
    if (crc_off || open_off || short_off || heat_off) st_nxt.shut = 1'b1;
    st_nxt.subst = st_nxt.shut ? 4'h0 : (crc_sub | open_sub | short_sub | heat_sub);
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r        <= '0;
      st_r.phase  <= aaw_pkg::AAW_IDLE;
      st_r.policy <= 8'(`AAW_POLICY_RST);
      st_r.code   <= 7'(`AAW_CODE_RST >> `AAW_CLAMP_BIT);
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops, except avs_waitrequest, which also decodes avs_read and avs_write
  assign avs_readdata               = st_r.rdata;
  assign avs_response               = st_r.resp;
  assign avs_waitrequest            = ~(st_r.phase == aaw_pkg::AAW_ANSWER) & (avs_read | avs_write);
  assign chan_disable_out           = {4{st_r.shut}};
  assign conv_disable_out           = st_r.shut;
  assign subst_out                  = st_r.subst;
  assign user_alarm_value_out       = st_r.code[6:1];
  assign high_side_clamp_select_out = st_r.code[0];

  // shutdown never releases without reset
  chk_shut_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r.shut |=> st_r.shut) else $error("shutdown released");
  // a kick write gives exactly one pulse
  chk_kick_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    kick_set |=> watchdog_kick_out ##1 !watchdog_kick_out) else $error("kick pulse wrong");
  // watchdog event sets flag
  chk_wdf_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wd_fault_in |=> st_r.wdf) else $error("watchdog flag missed");
  // crc event sets flag
  chk_crcf_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    crc_err_in |=> st_r.crcf) else $error("crc flag missed");
  // invalid code never acts
  chk_code_inval: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_r.policy == 8'hFF && !st_r.shut) |=> st_r.subst == 4'h0 && !st_r.shut)
    else $error("code 11 acted");
  // open-circuit substitution per channel
  chk_open_sub: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_r.policy == 8'h10 && !st_r.shut) |=> st_r.subst == $past(open_current_in))
    else $error("open substitution wrong");
  // overheat shutdown
  chk_heat_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_r.policy[1:0] == 2'h2 && overheat_in) |=> conv_disable_out && chan_disable_out == 4'hF)
    else $error("overheat shutdown missed");
  // crc/watchdog forces all channels
  chk_crcwd_all: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_r.policy == 8'h40 && fault_crcwd && !st_r.shut) |=> st_r.subst == 4'hF)
    else $error("crc substitution wrong");
  // policy write lands after answer
  chk_policy_wr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wr_acc && avs_address == `AAW_IDX_POLICY && avs_byteenable[0])
    |=> st_r.policy == $past(avs_writedata[7:0]))
    else $error("policy write lost");

  // a fresh request seen while the slave idles
  sequence seq_req_idle;
    (avs_read || avs_write) && st_r.phase == aaw_pkg::AAW_IDLE;
  endsequence
  // the answer cycle: stall dropped
  sequence seq_answer;
    !avs_waitrequest && st_r.phase == aaw_pkg::AAW_ANSWER;
  endsequence
  // every request stalls once, then completes
  chk_bus_answer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    seq_req_idle |-> avs_waitrequest ##1 seq_answer)
    else $error("bus answer late");
  // alarm value and clamp write land after answer
  chk_code_wr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wr_acc && avs_address == `AAW_IDX_CODE && avs_byteenable[1])
    |=> st_r.code == $past(avs_writedata[`AAW_VAL_HI:`AAW_CLAMP_BIT]))
    else $error("code write lost");
  // a restart pulse only follows a kick write
  chk_kick_cause: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    watchdog_kick_out |-> $past(kick_set))
    else $error("stray kick pulse");
  // identity read returns the fixed code
  chk_ident_rd: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (seq_req_idle and (avs_read && avs_address == `AAW_IDX_IDENT))
    |=> avs_readdata == {29'h00000000, ID_CODE})
    else $error("identity read wrong");
  // reserved slot reads zero
  chk_rsvd_rd: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (seq_req_idle and (avs_read && avs_address == `AAW_IDX_RSVD))
    |=> avs_readdata == 32'h0000_0000)
    else $error("reserved slot not zero");
  // crc/watchdog shutdown policy disables everything
  chk_crcwd_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_r.policy[7:6] == 2'h2 && fault_crcwd) |=> conv_disable_out && chan_disable_out == 4'hF)
    else $error("crc shutdown missed");
  // a clear with no new event drops the crc flag
  chk_flag_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wr_acc && avs_address == `AAW_IDX_FAULTS && avs_byteenable[0]
     && avs_writedata[`AAW_CRCF_BIT] && !crc_err_in) |=> !st_r.crcf)
    else $error("crc flag not cleared");
endmodule

// file: test/aaw_regs_test.sv
// bench for the alarm policy and watchdog register bank
module aaw_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  // one table row: policy, fault levels, expected substitution
  typedef struct packed {
    logic [7:0] pol;
    logic [3:0] opn;
    logic [3:0] sht;
    logic       hot;
    logic [3:0] sub;
  } aaw_row_s;
  logic        ref_clk_in;  // system clock
  logic        rst_in;      // sync reset
  logic [7:0]  addr;        // word index
  logic        rd;          // read request
  logic        wr;          // write request
  logic [31:0] wdata;       // write data
  logic [31:0] rdata;       // read data
  logic        wait_req;    // stall
  logic [1:0]  resp;        // response code
  logic        crc;         // crc event
  logic        wdf;         // watchdog event
  logic [3:0]  opn;         // open-circuit levels
  logic [3:0]  sht;         // short-circuit levels
  logic        hot;         // overheat level
  logic [3:0]  chan_off;    // channel disables
  logic        conv_off;    // converter disable
  logic [3:0]  sub;         // substituted channels
  logic [5:0]  val;         // alarm value
  logic        clamp;       // clamp select
  logic        kick;        // restart pulse
  logic [31:0] q;           // last read data
  logic [1:0]  r;           // last response
  int          n_mismatch;  // mismatches
  int          checked;     // comparisons
  int          n_kick;      // kick cycles seen
  aaw_row_s    rows [7] = '{
    '{8'h10, 4'h5, 4'h0, 1'b0, 4'h5}, '{8'h04, 4'h0, 4'hA, 1'b0, 4'hA},
    '{8'h01, 4'h0, 4'h0, 1'b1, 4'hF}, '{8'h00, 4'hF, 4'hF, 1'b1, 4'h0},
    '{8'hFF, 4'hF, 4'hF, 1'b1, 4'h0}, '{8'h14, 4'h1, 4'h2, 1'b0, 4'h3},
    '{8'h10, 4'h0, 4'hF, 1'b0, 4'h0}};
  aaw_regs #(.ID_CODE(3'h2)) i_aaw_regs (  // identity value arbitrary
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .avs_response(resp), .crc_err_in(crc), .wd_fault_in(wdf), .open_current_in(opn),
    .short_voltage_in(sht), .overheat_in(hot), .chan_disable_out(chan_off), .conv_disable_out(conv_off),
    .subst_out(sub), .user_alarm_value_out(val), .high_side_clamp_select_out(clamp),
    .watchdog_kick_out(kick));
  // free-running clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // count restart pulse cycles
  always @(posedge ref_clk_in) begin
    if (kick === 1'b1) n_kick++;
  end
  // verdict and end of run
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one bus transfer, held until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_in);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    // sample stall and data at the rising edge, before the slave updates
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_in);
      if (wait_req === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end
    q = rdata;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // settle a few cycles, sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  // sync reset for n cycles
  task automatic do_reset(input int n);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (n) @(posedge ref_clk_in);
    rst_in <= 1'b0;
  endtask
  // main sequence
  initial begin
    {rst_in, rd, wr, crc, wdf, hot} = '0;
    {addr, wdata, opn, sht} = '0;
    {n_mismatch, checked, n_kick} = '0;
    rst_in = 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // per-channel and all-channel substitution, invalid code
    foreach (rows[k]) begin
      bus(1'b1, 8'h0D, {24'h0, rows[k].pol});
      @(posedge ref_clk_in);
      {opn, sht, hot} <= {rows[k].opn, rows[k].sht, rows[k].hot};
      settle();
      chk({chan_off, conv_off, sub}, {5'h00, rows[k].sub});
      @(posedge ref_clk_in);
      {opn, sht, hot} <= '0;
    end
    // reset values, identity, reserved and unmapped places
    do_reset(2);
    bus(1'b0, 8'h0D, 0); chk(q, 0);
    bus(1'b0, 8'h0E, 0); chk(q, 0);
    bus(1'b1, 8'h0D, 32'h39); bus(1'b0, 8'h0D, 0); chk(q, 32'h39);
    bus(1'b1, 8'h0E, 32'hFE00); bus(1'b0, 8'h0E, 0); chk(q, 32'hFE00);
    chk({val, clamp}, 7'h7F);
    bus(1'b1, 8'h0F, 32'hFFFF); bus(1'b0, 8'h0F, 0); chk(q, 0);
    bus(1'b1, 8'h11, 32'hFFFF); bus(1'b0, 8'h11, 0); chk(q, 32'h2);
    bus(1'b0, 8'h13, 0); chk(q, 32'h0); chk(r, 32'h2);
    // watchdog kick: one pulse for a one, none for a zero
    n_kick = 0;
    bus(1'b1, 8'h10, 0); settle(); chk(n_kick, 0);
    bus(1'b1, 8'h10, 1); settle(); chk(n_kick, 1);
    // crc and watchdog events substitute on all channels
    bus(1'b1, 8'h0D, 32'h40);
    @(posedge ref_clk_in); crc <= 1'b1;
    @(posedge ref_clk_in); crc <= 1'b0;
    settle(); chk(sub, 4'hF);
    bus(1'b0, 8'h12, 0); chk(q, 32'h20);
    bus(1'b1, 8'h12, 32'h20); settle(); chk(sub, 4'h0);
    @(posedge ref_clk_in); wdf <= 1'b1;
    @(posedge ref_clk_in); wdf <= 1'b0;
    settle(); chk(sub, 4'hF);
    bus(1'b0, 8'h12, 0); chk(q, 32'h800);
    // shutdown of each field latches after the fault goes away
    for (int f = 0; f < 4; f++) begin
      do_reset(2);
      bus(1'b1, 8'h0D, 32'h2 << (2 * f));
      settle(); chk({chan_off, conv_off}, 5'h00);
      @(posedge ref_clk_in);
      {hot, sht, opn, crc} <= {f == 0, 3'h0, f == 1, 3'h0, f == 2, f == 3};
      @(posedge ref_clk_in); crc <= 1'b0;
      settle(); chk({chan_off, conv_off, sub}, 9'h1F0);
      @(posedge ref_clk_in); {hot, sht, opn} <= '0;
      bus(1'b1, 8'h12, 32'h820);
      settle(); chk({chan_off, conv_off}, 5'h1F);
    end
    conclude();
  end
endmodule
